// ### hw/uic_defines.svh
// register offsets, field positions, reset values and counts
`ifndef UIC_DEFINES_SVH
`define UIC_DEFINES_SVH

`define UIC_OFS_ISR        8'h00
`define UIC_OFS_FCR        8'h04
`define UIC_OFS_LCR        8'h08
`define UIC_OFS_IER        8'h0c
`define UIC_OFS_EFR        8'h10
`define UIC_OFS_FEATURE_CONTROL       8'h14
`define UIC_OFS_TRG_RX     8'h18
`define UIC_OFS_TRG_TX     8'h1c

`define UIC_RST_FCR        8'h00
`define UIC_RST_LCR        8'h00
`define UIC_RST_IER        8'h00
`define UIC_RST_EFR        8'h00
`define UIC_RST_FEATURE_CONTROL       8'h00
`define UIC_RST_TRG        8'h01

`define UIC_FCR_EN         0
`define UIC_FCR_RXRST      1
`define UIC_FCR_TXRST      2
`define UIC_FCR_DMA        3
`define UIC_EFR_ENH        4
`define UIC_EFR_ARTS       6
`define UIC_EFR_ACTS       7
`define UIC_FEATURE_CONTROL_RS485     3
`define UIC_IER_RXD        0
`define UIC_IER_TXR        1
`define UIC_IER_LSR        2
`define UIC_IER_MSR        3
`define UIC_IER_XOF        5
`define UIC_IER_RTS        6
`define UIC_IER_CTS        7

`define UIC_CODE_LSR       6'h06
`define UIC_CODE_TMO       6'h0c
`define UIC_CODE_RXD       6'h04
`define UIC_CODE_TXR       6'h02
`define UIC_CODE_MSR       6'h00
`define UIC_CODE_XOF       6'h10
`define UIC_CODE_FLW       6'h20
`define UIC_CODE_NONE      6'h01

`define UIC_TMO_CHARS      8'h04
`define UIC_TMO_BITS       8'h0c
`define UIC_FRAME_EXTRA    8'h02
`define UIC_MIN_WORD       8'h05

`endif

// ### hw/uic_pkg.sv
// types shared by the interrupt and fifo control block
package uic_pkg;

	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_LSR  = 3'b001,
		SRC_TMO  = 3'b010,
		SRC_RXD  = 3'b011,
		SRC_TXR  = 3'b100,
		SRC_MSR  = 3'b101,
		SRC_XOF  = 3'b110,
		SRC_FLW  = 3'b111
	} uic_src_t;

	typedef struct packed {
		logic [3:0] line_status_err;
		logic [3:0] modem_status_delta;
		logic       char_rx;
		logic       receive_holding_read;
		logic       line_status_read;
		logic       modem_status_read;
		logic       transmit_holding_write;
		logic       xoff_match;
		logic       xon_match;
		logic       special_match;
		logic       tx_empty;
		logic       bit_tick;
		logic       rts_n;
	} uic_evt_t;

	typedef struct packed {
		logic       fifo_enable;
		logic       dma_mode;
		logic       rx_fifo_reset;
		logic       tx_fifo_reset;
		logic [1:0] word_len;
		logic [7:0] rx_trigger;
		logic [7:0] tx_trigger;
	} uic_cfg_t;

endpackage : uic_pkg

// ### hw/uic_irq_fifo_ctrl.sv
// uart interrupt priority, fifo setup and word length control
// Operation
// RULE1: isr read returns highest pending, rest queued; a reported source is kept even when a higher one arrives
// RULE2: reported source held until it is serviced
// RULE3: codes for line status, timeout, data ready
// RULE4: codes for tx, modem, xoff, flow, none
// RULE5: bit0 low while pending, high otherwise
// RULE6: line status bits 1-4, modem bits 0-3
// RULE7: timeout after four chars plus twelve bits
// RULE8: tx ready on trigger/empty, rs485 on empty
// RULE9: xoff/special flag; cts/rts rising in auto
// RULE10: lsr read clears lsr; msr read clears msr/flow
// RULE11: data ready below trigger; timeout on read
// RULE12: tx ready cleared by isr read or write
// RULE13: xoff by isr read/xon; special by next char
// RULE14: bits 5:4 need enhanced bit; xoff sticky
// RULE15: bits 7:6 mirror fifo enable
// RULE16: fifo enable bit gates other setup bits
// RULE17: fifo reset pulses, self clearing
// RULE18: setup bit3 selects dma pin behaviour
// RULE19: tx trigger crossing or empty after low reload
// RULE20: rx trigger from setup bits 7:6, default one
// RULE21: feature bits 5:4 select trigger table
// RULE22: word length five to eight bits
// RULE23: mask gates sources into source register
`timescale 1ns/100ps
`include "uic_defines.svh"

module uic_irq_fifo_ctrl #(
	parameter int CNT_W = 8,
	parameter int DEPTH = 128
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire uic_pkg::uic_evt_t evt,
	input  wire logic [CNT_W-1:0]  rx_count,
	input  wire logic [CNT_W-1:0]  tx_count,
	input  wire logic              cts_n_pin,
	output uic_pkg::uic_cfg_t      cfg,
	output logic                   irq_active,
	output logic                   rx_data_indication_n,
	output logic                   tx_space_indication_n
);

	generate
		if (CNT_W < 8 || DEPTH < 64 || DEPTH >= (1 << CNT_W))
			$error("uic_irq_fifo_ctrl: bad CNT_W or DEPTH");
	endgenerate

	localparam logic [7:0] RX_TBL [0:11] = '{
		8'h01, 8'h04, 8'h08, 8'h0e,
		8'h08, 8'h10, 8'h18, 8'h1c,
		8'h08, 8'h10, 8'h38, 8'h3c};
	localparam logic [7:0] TX_TBL [0:11] = '{
		8'h01, 8'h01, 8'h01, 8'h01,
		8'h10, 8'h08, 8'h18, 8'h1e,
		8'h08, 8'h10, 8'h20, 8'h38};
	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

	logic [7:0]        fcr_q;
	logic [7:0]        lcr_q;
	logic [7:0]        ier_q;
	logic [7:0]        efr_q;
	logic [7:0]        feature_control_q;
	logic [7:0]        trg_rx_q;
	logic [7:0]        trg_tx_q;
	logic              pready_q;
	logic              pslverr_q;
	logic [31:0]       prdata_q;
	logic              cts_s1_q;
	logic              cts_s2_q;
	logic              cts_s3_q;
	logic              rts_q;
	logic [3:0]        lsr_q;
	logic [3:0]        msr_q;
	logic              tx_empty_q;
	logic              ier_tx_q;
	logic [CNT_W-1:0]  tx_prev_q;
	logic              tx_over_q;
	logic [7:0]        tmo_cnt_q;
	logic              p_lsr_q;
	logic              p_tmo_q;
	logic              p_txr_q;
	logic              p_msr_q;
	logic              p_xoff_q;
	logic              p_spec_q;
	logic              p_flw_q;
	logic              xoff_bit_q;
	uic_pkg::uic_src_t cur_q;
	uic_pkg::uic_src_t cur_d;
	uic_pkg::uic_cfg_t cfg_q;
	logic              irq_q;
	logic              rxi_n_q;
	logic              txi_n_q;

	logic              acc;
	logic              wr;
	logic              rd;
	logic              isr_rd;
	logic              enh;
	logic              fifo_en;
	logic [7:0]        rx_trig;
	logic [7:0]        tx_trig;
	logic [CNT_W-1:0]  rx_trig_c;
	logic [CNT_W-1:0]  tx_trig_c;
	logic [7:0]        tmo_limit;
	logic [7:0]        isr_val;
	logic [7:0]        rd_val;
	logic              mapped;
	logic              rxd_lvl;
	logic              txr_set;
	logic [7:0]        pend;

	assign acc    = psel & penable & pready_q;
	assign wr     = acc & pwrite;
	assign rd     = acc & ~pwrite;
	assign isr_rd = rd & (paddr == `UIC_OFS_ISR);
	assign enh    = efr_q[`UIC_EFR_ENH];
	assign fifo_en = fcr_q[`UIC_FCR_EN];

	// trigger lookup; table D takes the programmable levels
	always_comb
	begin
		case (feature_control_q[5:4]) // see RULE21
			2'b11:
			begin
				rx_trig = trg_rx_q;
				tx_trig = trg_tx_q;
			end
			default:
			begin
				rx_trig = RX_TBL[{feature_control_q[5:4], fcr_q[7:6]}]; // see RULE20
				tx_trig = TX_TBL[{feature_control_q[5:4], fcr_q[5:4]}]; // see RULE19
			end
		endcase
		// without fifos a single character is the level
		if (!fifo_en)
		begin
			rx_trig = 8'h01;
			tx_trig = 8'h01;
		end
	end
	assign rx_trig_c = CNT_W'(rx_trig);
	assign tx_trig_c = CNT_W'(tx_trig);

	// frame = start + data + one stop
	assign tmo_limit = `UIC_TMO_CHARS
		* (`UIC_MIN_WORD + {6'h00, lcr_q[1:0]} + `UIC_FRAME_EXTRA)
		+ `UIC_TMO_BITS; // see RULE7

	// apb: one wait state so read data comes from a flop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= ~mapped;
			prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_comb
	begin
		mapped = 1'b1;
		case (paddr)
			`UIC_OFS_ISR:    rd_val = isr_val;
			`UIC_OFS_FCR:    rd_val = 8'h00;
			`UIC_OFS_LCR:    rd_val = lcr_q;
			`UIC_OFS_IER:    rd_val = ier_q;
			`UIC_OFS_EFR:    rd_val = efr_q;
			`UIC_OFS_FEATURE_CONTROL:   rd_val = feature_control_q;
			`UIC_OFS_TRG_RX: rd_val = trg_rx_q;
			`UIC_OFS_TRG_TX: rd_val = trg_tx_q;
			default:
			begin
				rd_val = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	// control registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lcr_q    <= `UIC_RST_LCR;
			ier_q    <= `UIC_RST_IER;
			efr_q    <= `UIC_RST_EFR;
			feature_control_q   <= `UIC_RST_FEATURE_CONTROL;
			trg_rx_q <= `UIC_RST_TRG;
			trg_tx_q <= `UIC_RST_TRG;
		end
		else if (wr)
		begin
			case (paddr)
				`UIC_OFS_LCR:    lcr_q <= pwdata[7:0]; // see RULE22
				`UIC_OFS_IER:    ier_q <= enh ? pwdata[7:0]
					: {ier_q[7:4], pwdata[3:0]};
				`UIC_OFS_EFR:    efr_q <= pwdata[7:0];
				`UIC_OFS_FEATURE_CONTROL:   feature_control_q <= pwdata[7:0];
				`UIC_OFS_TRG_RX: trg_rx_q <= pwdata[7:0];
				`UIC_OFS_TRG_TX: trg_tx_q <= pwdata[7:0];
				default:         lcr_q <= lcr_q;
			endcase
		end
	end

	// fifo setup; reset bits are stored as one-cycle pulses
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fcr_q <= `UIC_RST_FCR;
		else if (wr && paddr == `UIC_OFS_FCR)
		begin
			fcr_q[`UIC_FCR_EN] <= pwdata[`UIC_FCR_EN]; // see RULE16
			if (pwdata[`UIC_FCR_EN])
			begin
				fcr_q[3:1] <= pwdata[3:1]; // see RULE17, RULE18
				fcr_q[7:6] <= pwdata[7:6];
				if (enh)
					fcr_q[5:4] <= pwdata[5:4]; // see RULE19
			end
			else
				fcr_q[2:1] <= 2'b00;
		end
		else
			fcr_q[2:1] <= 2'b00; // see RULE17
	end

	// cts arrives from a pin; rts is driven by on-chip logic
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cts_s1_q   <= 1'b1;
			cts_s2_q   <= 1'b1;
			cts_s3_q   <= 1'b1;
			rts_q      <= 1'b1;
			lsr_q      <= 4'h0;
			msr_q      <= 4'h0;
			tx_empty_q <= 1'b1;
			ier_tx_q   <= 1'b0;
			tx_prev_q  <= '0;
		end
		else
		begin
			cts_s1_q   <= cts_n_pin;
			cts_s2_q   <= cts_s1_q;
			cts_s3_q   <= cts_s2_q;
			rts_q      <= evt.rts_n;
			lsr_q      <= evt.line_status_err;
			msr_q      <= evt.modem_status_delta;
			tx_empty_q <= evt.tx_empty;
			ier_tx_q   <= ier_q[`UIC_IER_TXR];
			tx_prev_q  <= tx_count;
		end
	end

	// remembers whether the last reload went above the trigger
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tx_over_q <= 1'b0;
		else if (tx_count > tx_trig_c)
			tx_over_q <= 1'b1;
		else if (tx_count == '0)
			tx_over_q <= 1'b0;
	end

	always_comb
	begin
		if (feature_control_q[`UIC_FEATURE_CONTROL_RS485])
			txr_set = evt.tx_empty & ~tx_empty_q; // see RULE8
		else
			txr_set = (tx_prev_q >= tx_trig_c && tx_count < tx_trig_c)
				|| (tx_prev_q != '0 && tx_count == '0
				&& !tx_over_q); // see RULE8, RULE19
		// enabling the source while already empty also raises it
		if (ier_q[`UIC_IER_TXR] && !ier_tx_q && tx_count == '0)
			txr_set = 1'b1;
	end

	// receive timeout timer, restarted by any rx activity
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tmo_cnt_q <= 8'h00;
		else if (evt.char_rx || evt.receive_holding_read
			|| rx_count == '0 || !fifo_en || p_tmo_q)
			tmo_cnt_q <= 8'h00;
		else if (evt.bit_tick && tmo_cnt_q != tmo_limit)
			tmo_cnt_q <= tmo_cnt_q + 8'h01;
	end

	// sticky sources; a set in the clearing cycle wins, except timeout, whose set a holding read blocks
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			p_lsr_q    <= 1'b0;
			p_tmo_q    <= 1'b0;
			p_txr_q    <= 1'b0;
			p_msr_q    <= 1'b0;
			p_xoff_q   <= 1'b0;
			p_spec_q   <= 1'b0;
			p_flw_q    <= 1'b0;
			xoff_bit_q <= 1'b0;
		end
		else
		begin
			if (|(evt.line_status_err & ~lsr_q)) // see RULE6
				p_lsr_q <= 1'b1;
			else if (evt.line_status_read) // see RULE10
				p_lsr_q <= 1'b0;
			if (evt.bit_tick && tmo_cnt_q == tmo_limit - 8'h01
				&& !evt.char_rx && !evt.receive_holding_read)
				p_tmo_q <= 1'b1; // see RULE7
			else if (evt.receive_holding_read) // see RULE11
				p_tmo_q <= 1'b0;
			if (txr_set)
				p_txr_q <= 1'b1;
			else if (isr_rd || evt.transmit_holding_write) // see RULE12
				p_txr_q <= 1'b0;
			if (|(evt.modem_status_delta & ~msr_q)) // see RULE6
				p_msr_q <= 1'b1;
			else if (evt.modem_status_read) // see RULE10
				p_msr_q <= 1'b0;
			if (evt.xoff_match) // see RULE9
				p_xoff_q <= 1'b1;
			else if (isr_rd || evt.xon_match) // see RULE13
				p_xoff_q <= 1'b0;
			if (evt.special_match) // see RULE9
				p_spec_q <= 1'b1;
			else if (isr_rd || evt.char_rx) // see RULE13
				p_spec_q <= 1'b0;
			if ((efr_q[`UIC_EFR_ACTS] && cts_s2_q && !cts_s3_q)
				|| (efr_q[`UIC_EFR_ARTS] && evt.rts_n && !rts_q))
				p_flw_q <= 1'b1; // see RULE9
			else if (evt.modem_status_read) // see RULE10
				p_flw_q <= 1'b0;
			if (evt.xoff_match)
				xoff_bit_q <= 1'b1; // see RULE14
			else if (evt.xon_match)
				xoff_bit_q <= 1'b0;
		end
	end

	assign rxd_lvl = rx_count >= rx_trig_c; // see RULE11, RULE20

	// masked pending vector, index = priority
	always_comb
	begin
		pend[0] = 1'b0;
		pend[1] = p_lsr_q & ier_q[`UIC_IER_LSR]; // see RULE23
		pend[2] = p_tmo_q & ier_q[`UIC_IER_RXD];
		pend[3] = rxd_lvl & ier_q[`UIC_IER_RXD];
		pend[4] = p_txr_q & ier_q[`UIC_IER_TXR];
		pend[5] = p_msr_q & ier_q[`UIC_IER_MSR];
		pend[6] = (p_xoff_q | p_spec_q) & ier_q[`UIC_IER_XOF]
			& enh; // see RULE14
		pend[7] = p_flw_q & enh
			& (ier_q[`UIC_IER_RTS] | ier_q[`UIC_IER_CTS]);
	end

	// keep the reported source until it is no longer pending
	always_comb
	begin
		cur_d = cur_q;
		if (cur_q == uic_pkg::SRC_NONE || !pend[cur_q]) // see RULE2
		begin
			if (pend[1])
				cur_d = uic_pkg::SRC_LSR; // see RULE1
			else if (pend[2])
				cur_d = uic_pkg::SRC_TMO;
			else if (pend[3])
				cur_d = uic_pkg::SRC_RXD;
			else if (pend[4])
				cur_d = uic_pkg::SRC_TXR;
			else if (pend[5])
				cur_d = uic_pkg::SRC_MSR;
			else if (pend[6])
				cur_d = uic_pkg::SRC_XOF;
			else if (pend[7])
				cur_d = uic_pkg::SRC_FLW;
			else
				cur_d = uic_pkg::SRC_NONE;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cur_q <= uic_pkg::SRC_NONE;
		else
			cur_q <= cur_d;
	end

	always_comb
	begin
		case (cur_q) // see RULE3, RULE4, RULE5
			uic_pkg::SRC_LSR:  isr_val[5:0] = `UIC_CODE_LSR;
			uic_pkg::SRC_TMO:  isr_val[5:0] = `UIC_CODE_TMO;
			uic_pkg::SRC_RXD:  isr_val[5:0] = `UIC_CODE_RXD;
			uic_pkg::SRC_TXR:  isr_val[5:0] = `UIC_CODE_TXR;
			uic_pkg::SRC_MSR:  isr_val[5:0] = `UIC_CODE_MSR;
			uic_pkg::SRC_XOF:  isr_val[5:0] = `UIC_CODE_XOF;
			uic_pkg::SRC_FLW:  isr_val[5:0] = `UIC_CODE_FLW;
			default:           isr_val[5:0] = `UIC_CODE_NONE;
		endcase
		// xoff match stays visible until xon while some source is reported
		if (enh && xoff_bit_q && cur_q != uic_pkg::SRC_NONE)
			isr_val[4] = 1'b1; // see RULE14
		isr_val[7:6] = {fifo_en, fifo_en}; // see RULE15
	end

	// output flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// fifos off: the effective level is one character
			cfg_q   <= '{rx_trigger: `UIC_RST_TRG,
				tx_trigger: `UIC_RST_TRG, default: '0}; // see RULE20
			irq_q   <= 1'b0;
			rxi_n_q <= 1'b1;
			txi_n_q <= 1'b0;
		end
		else
		begin
			cfg_q.fifo_enable   <= fifo_en;
			cfg_q.dma_mode      <= fcr_q[`UIC_FCR_DMA];
			cfg_q.rx_fifo_reset <= fcr_q[`UIC_FCR_RXRST];
			cfg_q.tx_fifo_reset <= fcr_q[`UIC_FCR_TXRST];
			cfg_q.word_len      <= lcr_q[1:0]; // see RULE22
			cfg_q.rx_trigger    <= rx_trig;
			cfg_q.tx_trigger    <= tx_trig;
			irq_q <= cur_d != uic_pkg::SRC_NONE;
			if (fcr_q[`UIC_FCR_DMA]) // see RULE18
			begin
				rxi_n_q <= ~(rxd_lvl | p_tmo_q);
				txi_n_q <= tx_count >= DEPTH_C;
			end
			else
			begin
				rxi_n_q <= rx_count == '0;
				txi_n_q <= tx_count != '0;
			end
		end
	end

	assign prdata                = prdata_q;
	assign pready                = pready_q;
	assign pslverr               = pslverr_q;
	assign cfg                   = cfg_q;
	assign irq_active            = irq_q;
	assign rx_data_indication_n  = rxi_n_q;
	assign tx_space_indication_n = txi_n_q;

endmodule : uic_irq_fifo_ctrl

// ### tb/uic_irq_fifo_ctrl_monitor.sv
// port assertions for the interrupt and fifo control block
`timescale 1ns/100ps
module uic_irq_fifo_ctrl_monitor #(
	parameter int CNT_W = 8
) (
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic [CNT_W-1:0]  rx_count,
	input wire logic [CNT_W-1:0]  tx_count,
	input wire uic_pkg::uic_cfg_t cfg,
	input wire logic              rx_data_indication_n,
	input wire logic              tx_space_indication_n
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic done;
	assign done = psel && penable && pready;

	// two cycles allowed so a registered cfg copy may lag
	a_fifo_enable: assert property (done && pwrite && paddr == 8'h04
		|=> ##1 cfg.fifo_enable == $past(pwdata[0], 2)) else $error("fifo enable");
	a_word_len: assert property (done && pwrite && paddr == 8'h08
		|=> ##1 cfg.word_len == $past(pwdata[1:0], 2)) else $error("word length");
	a_isr_fifo_bits: assert property (done && !pwrite && paddr == 8'h00
		|-> prdata[7:6] == {2{cfg.fifo_enable}}) else $error("isr fifo bits");
	a_rx_rst_pulse: assert property ($rose(cfg.rx_fifo_reset)
		|-> cfg.fifo_enable ##1 !cfg.rx_fifo_reset) else $error("rx reset");
	a_tx_rst_pulse: assert property (cfg.tx_fifo_reset
		|=> !cfg.tx_fifo_reset) else $error("tx reset");
	a_trig_off: assert property (!cfg.fifo_enable && !$past(cfg.fifo_enable)
		|-> cfg.rx_trigger == 8'h01 && cfg.tx_trigger == 8'h01)
		else $error("trigger when off");
	a_rx_ind_norm: assert property (!cfg.dma_mode && rx_count != '0
		|=> !rx_data_indication_n) else $error("rx indication");
	a_tx_ind_norm: assert property (!cfg.dma_mode && tx_count == '0
		|=> !tx_space_indication_n) else $error("tx indication");
endmodule : uic_irq_fifo_ctrl_monitor

bind uic_irq_fifo_ctrl uic_irq_fifo_ctrl_monitor #(.CNT_W(CNT_W)) u_mon (.*);

// ### tb/uic_apb_host.sv
// apb master standing in for the host processor
`timescale 1ns/100ps
module uic_apb_host (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// request held unchanged until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		// released lines flip so stale values are never trusted
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : uic_apb_host

// ### tb/tb_top.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/100ps
`include "uic_defines.svh"
module tb_top;
	logic              clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]        paddr, rx_count, tx_count;
	logic [31:0]       pwdata, prdata;
	logic              cts_n_pin, irq_active;
	logic              rx_data_indication_n, tx_space_indication_n;
	logic [1:0]        rst_seen = 2'b00;
	uic_pkg::uic_evt_t evt;
	uic_pkg::uic_cfg_t cfg;
	int                error_cnt = 0;
	int                tests_run = 0;
	int                cyc = 0;
	logic [7:0]        rxt [3][4] = '{'{8'h01, 8'h04, 8'h08, 8'h0e},
		'{8'h08, 8'h10, 8'h18, 8'h1c}, '{8'h08, 8'h10, 8'h38, 8'h3c}};
	logic [7:0]        txt [3][4] = '{'{8'h01, 8'h01, 8'h01, 8'h01},
		'{8'h10, 8'h08, 8'h18, 8'h1e}, '{8'h08, 8'h10, 8'h20, 8'h38}};

	uic_irq_fifo_ctrl i_uic_irq_fifo_ctrl (.*);
	uic_apb_host u_host (.*);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rst_seen <= rst_seen | {cfg.rx_fifo_reset, cfg.tx_fifo_reset};
		if (cyc == 6000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b1, a, {24'h0, d}, r, e);
		@(posedge clk);
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd

	task automatic ev(input uic_pkg::uic_evt_t m);
		@(posedge clk);
		evt <= evt | m;
		@(posedge clk);
		evt <= evt & ~m;
		repeat (8) @(posedge clk);
	endtask : ev

	task automatic t_reset;
		chk({rx_data_indication_n, tx_space_indication_n}, 2'b10);
		rd(`UIC_OFS_ISR, 32'h01, 1'b0);
		wr(`UIC_OFS_ISR, 8'hff);
		rd(`UIC_OFS_ISR, 32'h01, 1'b0);
		rd(`UIC_OFS_FCR, 32'h00, 1'b0);
		rd(8'h40, 32'h00, 1'b1);
		for (int i = 3; i >= 0; i--)
		begin
			wr(`UIC_OFS_LCR, 8'(i));
			chk(cfg.word_len, i);
			rd(`UIC_OFS_LCR, i, 1'b0);
		end
		$display("t_reset done");
	endtask : t_reset

	task automatic t_fifo;
		tx_count <= 8'h05;
		wr(`UIC_OFS_FCR, 8'h01);
		chk(cfg.fifo_enable, 1'b1);
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		// dma bit written with the enable low must be dropped
		wr(`UIC_OFS_FCR, 8'h08);
		chk({cfg.fifo_enable, cfg.dma_mode}, 2'b00);
		rd(`UIC_OFS_ISR, 32'h01, 1'b0);
		wr(`UIC_OFS_FCR, 8'h0f);
		repeat (3) @(negedge clk);
		chk(rst_seen, 2'b11);
		chk({cfg.rx_fifo_reset, cfg.tx_fifo_reset}, 2'b00);
		chk({cfg.dma_mode, tx_space_indication_n}, 2'b10);
		wr(`UIC_OFS_FCR, 8'h01);
		chk({cfg.dma_mode, tx_space_indication_n}, 2'b01);
		$display("t_fifo done");
	endtask : t_fifo

	task automatic t_trig;
		wr(`UIC_OFS_EFR, 8'h10);
		for (int t = 0; t < 3; t++)
		begin
			wr(`UIC_OFS_FEATURE_CONTROL, {2'b00, t[1:0], 4'h0});
			for (int i = 0; i < 4; i++)
			begin
				wr(`UIC_OFS_FCR, {i[1:0], ((t == 0) ? 2'b00 : i[1:0]), 4'h1});
				chk(cfg.rx_trigger, rxt[t][i]);
				chk(cfg.tx_trigger, txt[t][i]);
			end
		end
		wr(`UIC_OFS_FEATURE_CONTROL, 8'h30);
		wr(`UIC_OFS_TRG_RX, 8'h25);
		wr(`UIC_OFS_TRG_TX, 8'h11);
		chk({cfg.rx_trigger, cfg.tx_trigger}, 16'h2511);
		wr(`UIC_OFS_FEATURE_CONTROL, 8'h00);
		wr(`UIC_OFS_FCR, 8'h01);
		$display("t_trig done");
	endtask : t_trig

	task automatic t_prio;
		wr(`UIC_OFS_IER, 8'h0f);
		ev('{transmit_holding_write: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		ev('{line_status_err: 4'h4, modem_status_delta: 4'h1, default: '0});
		chk(irq_active, 1'b1);
		rd(`UIC_OFS_ISR, 32'hc6, 1'b0);
		rd(`UIC_OFS_ISR, 32'hc6, 1'b0);
		ev('{line_status_read: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc0, 1'b0);
		ev('{modem_status_read: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		rx_count <= 8'h01;
		rd(`UIC_OFS_ISR, 32'hc4, 1'b0);
		rx_count <= 8'h00;
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		tx_count <= 8'h00;
		rd(`UIC_OFS_ISR, 32'hc2, 1'b0);
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		wr(`UIC_OFS_IER, 8'h00);
		@(posedge clk);
		rx_count <= 8'h01;
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		rx_count <= 8'h00;
		$display("t_prio done");
	endtask : t_prio

	task automatic t_flow;
		wr(`UIC_OFS_EFR, 8'h90);
		wr(`UIC_OFS_IER, 8'ha0);
		ev('{xoff_match: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hd0, 1'b0);
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		cts_n_pin <= 1'b1;
		repeat (8) @(posedge clk);
		rd(`UIC_OFS_ISR, 32'hf0, 1'b0);
		ev('{xon_match: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'he0, 1'b0);
		ev('{modem_status_read: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		ev('{special_match: 1'b1, default: '0});
		ev('{char_rx: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		ev('{special_match: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hd0, 1'b0);
		$display("t_flow done");
	endtask : t_flow

	task automatic t_rs485;
		wr(`UIC_OFS_FEATURE_CONTROL, 8'h08);
		// enabling the source with the fifo empty raises it at once
		wr(`UIC_OFS_IER, 8'h02);
		rd(`UIC_OFS_ISR, 32'hc2, 1'b0);
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		ev('{tx_empty: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc2, 1'b0);
		ev('{transmit_holding_write: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		wr(`UIC_OFS_FEATURE_CONTROL, 8'h00);
		$display("t_rs485 done");
	endtask : t_rs485

	task automatic t_tmo;
		wr(`UIC_OFS_IER, 8'h01);
		wr(`UIC_OFS_FCR, 8'hc1);
		@(posedge clk);
		rx_count <= 8'h01;
		// one tick short of four 5-bit frames plus twelve bits
		repeat (`UIC_TMO_CHARS * (`UIC_MIN_WORD + `UIC_FRAME_EXTRA)
			+ `UIC_TMO_BITS - 8'h01)
			ev('{bit_tick: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		ev('{bit_tick: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hcc, 1'b0);
		ev('{receive_holding_read: 1'b1, default: '0});
		rd(`UIC_OFS_ISR, 32'hc1, 1'b0);
		rx_count <= 8'h00;
		$display("t_tmo done");
	endtask : t_tmo

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		resetn = 1'b0;
		evt = '0;
		rx_count = 8'h00;
		tx_count = 8'h00;
		cts_n_pin = 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_fifo();
		t_trig();
		t_prio();
		t_flow();
		t_rs485();
		t_tmo();
		print_verdict();
	end
endmodule : tb_top
